// >>> ocp_bus_model.sv
`timescale 1ns/100ps
module ocp_bus_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // panel master side
  input wire logic i_master_reset,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] i_lat,
  output logic o_ack,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:255];
  logic [3:0] cnt;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {i[7:0], ~i[7:0]};
  end
  // one completion per request after i_lat waits; data wanders when not valid
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ack <= 1'b0;
      cnt <= 4'h0;
      o_rdata <= 16'h0000;
    end
    else if (i_master_reset || o_ack || !i_req)
    begin
      o_ack <= 1'b0;
      cnt <= 4'h0;
      o_rdata <= ~o_rdata;
    end
    else if (cnt == i_lat)
    begin
      o_ack <= 1'b1;
      if (i_we)
        mem[i_addr[7:0]] <= i_wdata;
      o_rdata <= i_we ? ~o_rdata : mem[i_addr[7:0]];
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule : ocp_bus_model

// >>> ocp_panel.sv
// Operation
// - attention switch raises a level one interrupt request to the processor
// - inhibit setting suppresses interrupt levels 1 to 4 and lights indicator
// - halt switch stops a running processor; no action when already halted
// - run switch starts execution from the current program counter
// - autoload switch starts transfer of one block from input device
// - autoload accepted only when armed by a preceding master reset
// - master reset switch resets system, arms autoload, lights its indicator
// - during master reset the bus and all modules stay inactive
// - power event switch off blocks power fail, recovery, line interrupts
// - completion indicator lights when the panel's own bus access ends
// - halt indicator lit only when processor neither runs nor waits
// - run indicator lit while processor fetches and executes
// - idle indicator lit while processor waits for a function to complete
// - panel bus accesses proceed without halting the processor
// - selector in address position takes switches as next target address
// - read fetches addressed location and shows word on display register
// - write stores switch data word into the captured target location
// - display holds read word; write data comes straight from switches
// - switch up is logic one, switch down is logic zero
// - one 16-bit display register, sixteen shared address/data switches
// - switches act only while the keylock reports enable; the power event switch acts regardless of the keylock
// - display register is addressable by software for operator messages
`timescale 1ns/100ps
module ocp_panel #(
  parameter int WORD_W = ocp_pkg::WORD_W,
  parameter int RESET_HOLD_NS = ocp_pkg::RESET_HOLD_NS
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // axi4-lite slave
  input wire logic [ocp_pkg::AXI_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ocp_pkg::AXI_DW-1:0] i_wdata,
  input wire logic [ocp_pkg::AXI_SW-1:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ocp_pkg::AXI_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [ocp_pkg::AXI_DW-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // panel switches
  input wire logic [WORD_W-1:0] i_sw_data,
  input wire logic i_sel_addr,
  input wire logic i_key_enable,
  input wire logic i_power_event_interrupt_switch,
  input wire logic i_operator_attention,
  input wire logic i_interrupt_inhibit,
  input wire logic i_sw_halt,
  input wire logic i_sw_run,
  input wire logic i_sw_load,
  input wire logic i_sw_reset,
  input wire logic i_sw_read,
  input wire logic i_sw_write,
  input wire logic i_register_load_switch,
  // panel indicators
  output logic [WORD_W-1:0] o_display,
  output logic o_led_run,
  output logic o_led_halt,
  output logic o_led_idle,
  output logic o_led_done,
  output logic o_led_load,
  output logic o_led_inhibit,
  // processor status and control
  input wire logic i_cpu_running,
  input wire logic i_cpu_waiting,
  output logic o_cpu_halt,
  output logic o_cpu_run,
  output logic o_autoload_start,
  output logic o_master_reset,
  // interrupt control
  input wire logic i_irq_operator_attention_ack,
  output logic o_irq_operator_attention,
  output logic o_irq_inhibit,
  output logic o_power_irq_block,
  // system bus master
  output logic o_bm_req,
  output logic o_bm_we,
  output logic [WORD_W-1:0] o_bm_addr,
  output logic [WORD_W-1:0] o_bm_wdata,
  input wire logic i_bm_ack,
  input wire logic [WORD_W-1:0] i_bm_rdata
);
  localparam int SYNC_W = ocp_pkg::DATA_LSB + WORD_W;
  localparam int HOLD_CYC =
    (RESET_HOLD_NS + ocp_pkg::CLK_PERIOD_NS - 1) / ocp_pkg::CLK_PERIOD_NS;
  localparam int RC_W = $clog2(HOLD_CYC + 1);
  localparam logic [RC_W-1:0] HOLD_LOAD = RC_W'(HOLD_CYC);
  generate
    if (WORD_W < 1 || WORD_W > ocp_pkg::AXI_DW || RESET_HOLD_NS < 1)
    begin : g_bad_param
      $error("ocp_panel: unsupported parameter value");
    end
  endgenerate
  function automatic logic reg_hit(input logic [ocp_pkg::AXI_AW-1:0] a,
                                   input logic [ocp_pkg::AXI_AW-1:0] off);
    reg_hit = (a[ocp_pkg::AXI_AW-1:2] == off[ocp_pkg::AXI_AW-1:2]);
  endfunction : reg_hit
  function automatic logic [WORD_W-1:0] strb_merge(input logic [WORD_W-1:0] old,
    input logic [ocp_pkg::AXI_DW-1:0] d, input logic [ocp_pkg::AXI_SW-1:0] s);
    logic [WORD_W-1:0] r;
    r = old;
    for (int i = 0; i < WORD_W; i++)
      if (s[i / 8])
        r[i] = d[i];
    strb_merge = r;
  endfunction : strb_merge
  // switch synchronisers
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  assign raw = {i_sw_data, i_power_event_interrupt_switch, i_key_enable, i_sel_addr,
                i_register_load_switch, i_sw_write, i_sw_read, i_sw_reset, i_sw_load,
                i_sw_run, i_sw_halt, i_interrupt_inhibit, i_operator_attention};
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : g_sync
      always_ff @(posedge i_clk or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
        end
        else
        begin
          s1[g] <= raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
        end
      end
    end
  endgenerate
  wire key_en = s2[ocp_pkg::LV_KEY];
  wire sel_addr = s2[ocp_pkg::LV_SEL];
  wire pwr_on = s2[ocp_pkg::LV_PWR];
  wire [WORD_W-1:0] sw_word = s2[SYNC_W-1:ocp_pkg::DATA_LSB];
  wire [ocp_pkg::SW_N-1:0] act =
    s2[ocp_pkg::SW_N-1:0] & ~s3[ocp_pkg::SW_N-1:0] & {ocp_pkg::SW_N{key_en}};
  // master reset sequencing
  logic [RC_W-1:0] rst_cnt;
  logic armed;
  wire in_reset = (rst_cnt != '0);
  wire [RC_W-1:0] next_rst_cnt = act[ocp_pkg::SW_RESET] ? HOLD_LOAD :
                                 (in_reset ? rst_cnt - 1'b1 : rst_cnt);
  wire load_go = act[ocp_pkg::SW_LOAD] & armed & ~in_reset;
  wire next_armed = act[ocp_pkg::SW_RESET] | (armed & ~load_go);
  wire cpu_halted = ~i_cpu_running & ~i_cpu_waiting;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_cnt <= '0;
      armed <= 1'b0;
      o_master_reset <= 1'b0;
      o_led_load <= 1'b0;
      o_autoload_start <= 1'b0;
      o_cpu_halt <= 1'b0;
      o_cpu_run <= 1'b0;
      o_led_run <= 1'b0;
      o_led_idle <= 1'b0;
      o_led_halt <= 1'b0;
    end
    else
    begin
      rst_cnt <= next_rst_cnt;
      armed <= next_armed;
      o_master_reset <= (next_rst_cnt != '0);
      o_led_load <= next_armed;
      o_autoload_start <= load_go;
      o_cpu_halt <= act[ocp_pkg::SW_HALT] & ~cpu_halted & ~in_reset;
      o_cpu_run <= act[ocp_pkg::SW_RUN] & cpu_halted & ~in_reset;
      o_led_run <= i_cpu_running;
      o_led_idle <= ~i_cpu_running & i_cpu_waiting;
      o_led_halt <= cpu_halted;
    end
  end
  // axi write channel state
  logic aw_full;
  logic w_full;
  logic [ocp_pkg::AXI_AW-1:0] aw_addr;
  logic [ocp_pkg::AXI_DW-1:0] w_data;
  logic [ocp_pkg::AXI_SW-1:0] w_strb;
  wire aw_take = i_awvalid & o_awready;
  wire w_take = i_wvalid & o_wready;
  wire wr_go = aw_full & w_full & ~o_bvalid;
  wire next_aw_full = (aw_full & ~wr_go) | aw_take;
  wire next_w_full = (w_full & ~wr_go) | w_take;
  wire wr_disp = wr_go & reg_hit(aw_addr, ocp_pkg::REG_DISPLAY);
  wire wr_ctrl = wr_go & reg_hit(aw_addr, ocp_pkg::REG_CONTROL);
  wire wr_mapped = wr_disp | wr_ctrl | reg_hit(aw_addr, ocp_pkg::REG_STATUS);
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= ocp_pkg::RESP_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      o_awready <= ~next_aw_full;
      o_wready <= ~next_w_full;
      if (aw_take)
      begin
        aw_addr <= i_awaddr;
      end
      if (w_take)
      begin
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_mapped ? ocp_pkg::RESP_OKAY : ocp_pkg::RESP_SLVERR;
      end
      else if (i_bready)
      begin
        o_bvalid <= 1'b0;
      end
    end
  end
  // operator attention, inhibit and power event blocking
  logic operator_attention_pend;
  logic inhibit;
  wire operator_attention_set = act[ocp_pkg::SW_OPERATOR_ATTENTION] & ~in_reset;
  wire next_operator_attention = operator_attention_set | (operator_attention_pend & ~i_irq_operator_attention_ack);
  wire next_inhibit = act[ocp_pkg::SW_INHIBIT] ? ~inhibit :
                      (wr_ctrl & w_strb[0]) ? w_data[ocp_pkg::CTRL_INHIBIT_BIT] :
                      inhibit;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      operator_attention_pend <= 1'b0;
      inhibit <= ocp_pkg::INHIBIT_RST;
      o_irq_operator_attention <= 1'b0;
      o_irq_inhibit <= ocp_pkg::INHIBIT_RST;
      o_led_inhibit <= ocp_pkg::INHIBIT_RST;
      o_power_irq_block <= 1'b0;
    end
    else
    begin
      operator_attention_pend <= next_operator_attention;
      inhibit <= next_inhibit;
      o_irq_operator_attention <= next_operator_attention & ~next_inhibit & ~in_reset;
      o_irq_inhibit <= next_inhibit;
      o_led_inhibit <= next_inhibit;
      o_power_irq_block <= ~pwr_on;
    end
  end
  // panel bus master
  ocp_pkg::ocp_bm_state_t bm_state;
  logic [WORD_W-1:0] target;
  wire bm_idle = (bm_state == ocp_pkg::OCP_BM_IDLE);
  wire [WORD_W-1:0] next_target = (sel_addr & key_en & bm_idle) ? sw_word : target;
  wire start_rd = act[ocp_pkg::SW_READ] & bm_idle & ~in_reset;
  wire start_wr = act[ocp_pkg::SW_WRITE] & ~act[ocp_pkg::SW_READ] & bm_idle & ~in_reset;
  wire bm_end = ~bm_idle & i_bm_ack & ~in_reset;
  wire rd_return = bm_end & ~o_bm_we;
  // display register: bus read return, then software, then load switch
  wire [WORD_W-1:0] next_display =
    rd_return ? i_bm_rdata :
    wr_disp ? strb_merge(o_display, w_data, w_strb) :
    act[ocp_pkg::SW_LOADREG] ? sw_word : o_display;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bm_state <= ocp_pkg::OCP_BM_IDLE;
      target <= '0;
      o_bm_req <= 1'b0;
      o_bm_we <= 1'b0;
      o_bm_addr <= '0;
      o_bm_wdata <= '0;
      o_led_done <= 1'b0;
      o_display <= ocp_pkg::DISPLAY_RST;
    end
    else
    begin
      target <= next_target;
      o_display <= next_display;
      case (bm_state)
        ocp_pkg::OCP_BM_IDLE:
        begin
          if (start_rd | start_wr)
          begin
            bm_state <= ocp_pkg::OCP_BM_CYCLE;
            o_bm_req <= 1'b1;
            o_bm_we <= start_wr;
            o_bm_addr <= next_target;
            o_bm_wdata <= sw_word;
            o_led_done <= 1'b0;
          end
        end
        ocp_pkg::OCP_BM_CYCLE:
        begin
          if (in_reset)
          begin
            bm_state <= ocp_pkg::OCP_BM_IDLE;
            o_bm_req <= 1'b0;
          end
          else if (i_bm_ack)
          begin
            bm_state <= ocp_pkg::OCP_BM_IDLE;
            o_bm_req <= 1'b0;
            o_led_done <= 1'b1;
          end
        end
        default:
        begin
          bm_state <= ocp_pkg::OCP_BM_IDLE;
          o_bm_req <= 1'b0;
        end
      endcase
    end
  end
  // axi read channel
  logic [ocp_pkg::AXI_DW-1:0] rd_word;
  logic rd_mapped;
  wire ar_take = i_arvalid & o_arready;
  wire next_rvalid = ar_take | (o_rvalid & ~i_rready);
  always_comb
  begin
    rd_word = '0;
    rd_mapped = 1'b1;
    if (reg_hit(i_araddr, ocp_pkg::REG_DISPLAY))
    begin
      rd_word[WORD_W-1:0] = o_display;
    end
    else if (reg_hit(i_araddr, ocp_pkg::REG_CONTROL))
    begin
      rd_word[ocp_pkg::CTRL_INHIBIT_BIT] = inhibit;
      rd_word[ocp_pkg::CTRL_PWR_BLOCK_BIT] = o_power_irq_block;
    end
    else if (reg_hit(i_araddr, ocp_pkg::REG_STATUS))
    begin
      rd_word[ocp_pkg::STAT_RUN_BIT] = o_led_run;
      rd_word[ocp_pkg::STAT_HALT_BIT] = o_led_halt;
      rd_word[ocp_pkg::STAT_IDLE_BIT] = o_led_idle;
      rd_word[ocp_pkg::STAT_DONE_BIT] = o_led_done;
      rd_word[ocp_pkg::STAT_ARMED_BIT] = armed;
      rd_word[ocp_pkg::STAT_BUSY_BIT] = ~bm_idle;
      rd_word[ocp_pkg::STAT_MRESET_BIT] = in_reset;
      rd_word[ocp_pkg::STAT_OPERATOR_ATTENTION_BIT] = operator_attention_pend;
    end
    else
    begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= ocp_pkg::RESP_OKAY;
    end
    else
    begin
      o_rvalid <= next_rvalid;
      o_arready <= ~next_rvalid;
      if (ar_take)
      begin
        o_rdata <= rd_word;
        o_rresp <= rd_mapped ? ocp_pkg::RESP_OKAY : ocp_pkg::RESP_SLVERR;
      end
    end
  end

endmodule : ocp_panel

// >>> ocp_panel_assertions.sv
`timescale 1ns/100ps
module ocp_panel_checker #(
  parameter int WORD_W = ocp_pkg::WORD_W
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // watched inputs
  input wire logic i_cpu_running,
  input wire logic i_cpu_waiting,
  input wire logic i_power_event_interrupt_switch,
  input wire logic i_irq_operator_attention_ack,
  input wire logic i_bm_ack,
  input wire logic [WORD_W-1:0] i_bm_rdata,
  // watched outputs
  input wire logic o_bm_req,
  input wire logic o_bm_we,
  input wire logic [WORD_W-1:0] o_bm_addr,
  input wire logic [WORD_W-1:0] o_display,
  input wire logic o_led_run,
  input wire logic o_led_halt,
  input wire logic o_led_idle,
  input wire logic o_led_done,
  input wire logic o_led_load,
  input wire logic o_led_inhibit,
  input wire logic o_cpu_halt,
  input wire logic o_cpu_run,
  input wire logic o_autoload_start,
  input wire logic o_master_reset,
  input wire logic o_irq_operator_attention,
  input wire logic o_irq_inhibit,
  input wire logic o_power_irq_block
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_bm_hold;
    disable iff (!i_nrst || o_master_reset)
    o_bm_req && !i_bm_ack |=> o_bm_req && $stable(o_bm_addr) && $stable(o_bm_we);
  endproperty
  a_bm_hold: assert property (p_bm_hold) else $error("bus request changed before ack");
  property p_ack_done;
    disable iff (!i_nrst || o_master_reset)
    o_bm_req && i_bm_ack |=> !o_bm_req && o_led_done;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("no done after bus ack");
  property p_read_disp;
    disable iff (!i_nrst || o_master_reset)
    o_bm_req && !o_bm_we && i_bm_ack |=> o_display == $past(i_bm_rdata);
  endproperty
  a_read_disp: assert property (p_read_disp) else $error("read word not on display");
  property p_mreset_quiet;
    o_master_reset && $past(o_master_reset) |-> !o_bm_req && !o_cpu_run && !o_autoload_start;
  endproperty
  a_mreset_quiet: assert property (p_mreset_quiet) else $error("activity in master reset");
  property p_leds;
    $past(i_nrst, 3) |-> o_led_run == $past(i_cpu_running)
      && o_led_halt == (!$past(i_cpu_running) && !$past(i_cpu_waiting))
      && o_led_idle == (!$past(i_cpu_running) && $past(i_cpu_waiting));
  endproperty
  a_leds: assert property (p_leds) else $error("state lights wrong");
  property p_pwr;
    (i_nrst && $stable(i_power_event_interrupt_switch))[*6]
      |-> o_power_irq_block == !i_power_event_interrupt_switch;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power interrupt block wrong");
  property p_inhibit;
    o_irq_inhibit && $past(o_irq_inhibit) |-> !o_irq_operator_attention && o_led_inhibit;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("request not masked");
  property p_operator_attention_ack;
    o_irq_operator_attention && i_irq_operator_attention_ack |=> !o_irq_operator_attention;
  endproperty
  a_operator_attention_ack: assert property (p_operator_attention_ack) else $error("attention not cleared");
  property p_halt;
    o_cpu_halt |-> $past(i_cpu_running) || $past(i_cpu_waiting);
  endproperty
  a_halt: assert property (p_halt) else $error("halt while halted");
  property p_run;
    o_cpu_run |-> !$past(i_cpu_running) && !$past(i_cpu_waiting) ##1 !o_cpu_run;
  endproperty
  a_run: assert property (p_run) else $error("bad run pulse");
  property p_load;
    o_autoload_start |-> $past(o_led_load) ##1 !o_led_load;
  endproperty
  a_load: assert property (p_load) else $error("autoload not armed");
  property p_arm;
    $rose(o_master_reset) |-> o_led_load;
  endproperty
  a_arm: assert property (p_arm) else $error("autoload not armed by reset");
  c_read: cover property (o_bm_req && !o_bm_we && i_bm_ack);
  c_write: cover property (o_bm_req && o_bm_we && i_bm_ack);
  c_load: cover property (o_autoload_start);
endmodule : ocp_panel_checker

bind ocp_panel ocp_panel_checker #(.WORD_W(WORD_W)) u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_cpu_running(i_cpu_running), .i_cpu_waiting(i_cpu_waiting),
  .i_power_event_interrupt_switch(i_power_event_interrupt_switch),
  .i_irq_operator_attention_ack(i_irq_operator_attention_ack), .i_bm_ack(i_bm_ack), .i_bm_rdata(i_bm_rdata),
  .o_bm_req(o_bm_req), .o_bm_we(o_bm_we), .o_bm_addr(o_bm_addr), .o_display(o_display),
  .o_led_run(o_led_run), .o_led_halt(o_led_halt), .o_led_idle(o_led_idle),
  .o_led_done(o_led_done), .o_led_load(o_led_load), .o_led_inhibit(o_led_inhibit),
  .o_cpu_halt(o_cpu_halt), .o_cpu_run(o_cpu_run), .o_autoload_start(o_autoload_start),
  .o_master_reset(o_master_reset), .o_irq_operator_attention(o_irq_operator_attention), .o_irq_inhibit(o_irq_inhibit),
  .o_power_irq_block(o_power_irq_block));

// >>> ocp_panel_tb.sv
`timescale 1ns/100ps
module ocp_panel_tb;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [15:0] i_sw_data = 16'h0000;
  logic [8:0] sw = 9'h000;
  logic i_sel_addr = 1'b0, i_key_enable = 1'b1, i_power_event_interrupt_switch = 1'b1;
  logic i_cpu_running = 1'b0, i_cpu_waiting = 1'b0, i_irq_operator_attention_ack = 1'b0;
  logic [3:0] lat = 4'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_bm_req, o_bm_we, i_bm_ack;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [15:0] o_display, o_bm_addr, o_bm_wdata, i_bm_rdata;
  logic o_led_run, o_led_halt, o_led_idle, o_led_done, o_led_load, o_led_inhibit;
  logic o_cpu_halt, o_cpu_run, o_autoload_start, o_master_reset;
  logic o_irq_operator_attention, o_irq_inhibit, o_power_irq_block, req_d = 1'b0;
  int mismatches = 0, cmp_count = 0, n_req = 0, n_halt = 0, n_run = 0, n_load = 0;

  always #2.5 i_clk = ~i_clk;

  ocp_panel #(.RESET_HOLD_NS(100)) u_dut (.i_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb(4'hf), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_sw_data, .i_sel_addr,
    .i_key_enable, .i_power_event_interrupt_switch, .i_operator_attention(sw[0]),
    .i_interrupt_inhibit(sw[1]), .i_sw_halt(sw[2]), .i_sw_run(sw[3]), .i_sw_load(sw[4]),
    .i_sw_reset(sw[5]), .i_sw_read(sw[6]), .i_sw_write(sw[7]), .i_register_load_switch(sw[8]),
    .o_display, .o_led_run, .o_led_halt, .o_led_idle, .o_led_done, .o_led_load,
    .o_led_inhibit, .i_cpu_running, .i_cpu_waiting, .o_cpu_halt, .o_cpu_run, .o_autoload_start,
    .o_master_reset, .i_irq_operator_attention_ack, .o_irq_operator_attention, .o_irq_inhibit, .o_power_irq_block,
    .o_bm_req, .o_bm_we, .o_bm_addr, .o_bm_wdata, .i_bm_ack, .i_bm_rdata);

  ocp_bus_model u_bus (.i_clk(i_clk), .i_nrst(i_nrst), .i_master_reset(o_master_reset),
    .i_req(o_bm_req), .i_we(o_bm_we), .i_addr(o_bm_addr), .i_wdata(o_bm_wdata),
    .i_lat(lat), .o_ack(i_bm_ack), .o_rdata(i_bm_rdata));

  // counts bus cycles and control pulses
  always @(posedge i_clk)
  begin
    req_d <= o_bm_req;
    if (o_bm_req && !req_d)
      n_req++;
    if (o_cpu_halt)
      n_halt++;
    if (o_cpu_run)
      n_run++;
    if (o_autoload_start)
      n_load++;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge i_clk);
  endtask : ticks

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_pend;
    logic w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (aw_pend || w_pend)
    begin
      @(posedge i_clk);
      if (aw_pend && o_awready)
      begin
        aw_pend = 1'b0;
        i_awvalid <= 1'b0;
      end
      if (w_pend && o_wready)
      begin
        w_pend = 1'b0;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (!o_bvalid);
    i_bready <= 1'b0;
    chk("bresp", r, o_bresp);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk); while (!o_rvalid);
    i_rready <= 1'b0;
    chk("rresp", r, o_rresp);
    chk("rdata", d, o_rdata);
  endtask : axr

  task automatic press(input int b);
    sw[b] <= 1'b1;
    ticks(6);
    sw[b] <= 1'b0;
    ticks(6);
  endtask : press

  task automatic cmd(input int b);
    press(b);
    for (int i = 0; i < 40 && !(o_led_done && !o_bm_req); i++)
      ticks(1);
  endtask : cmd

  initial
  begin
    ticks(20000);
    mismatches++;
    results();
  end

  initial
  begin
    ticks(6);
    i_nrst <= 1'b1;
    ticks(2);
    axw(ocp_pkg::REG_DISPLAY, 32'h0000_5a3c, ocp_pkg::RESP_OKAY);
    axr(ocp_pkg::REG_DISPLAY, 32'h0000_5a3c, ocp_pkg::RESP_OKAY);
    axr(8'h0c, 32'h0000_0000, ocp_pkg::RESP_SLVERR);
    axw(8'h0c, 32'h0000_0001, ocp_pkg::RESP_SLVERR);
    axw(ocp_pkg::REG_CONTROL, 32'h0000_0001, ocp_pkg::RESP_OKAY);
    chk("inhibit", 1, o_led_inhibit);
    axw(ocp_pkg::REG_CONTROL, 32'h0000_0000, ocp_pkg::RESP_OKAY);
    chk("inhibit", 0, o_led_inhibit);
    for (int k = 0; k < 3; k++)
    begin
      i_cpu_running <= (k == 1);
      i_cpu_waiting <= (k == 2);
      ticks(3);
      chk("led_halt", k == 0, o_led_halt);
      chk("led_run", k == 1, o_led_run);
      chk("led_idle", k == 2, o_led_idle);
    end
    i_cpu_waiting <= 1'b0;
    i_cpu_running <= 1'b1;
    i_sel_addr <= 1'b1;
    i_sw_data <= 16'h0123;
    lat <= 4'h5;
    cmd(6);
    chk("display", 32'h0000_23dc, o_display);
    chk("done", 1, o_led_done);
    i_sel_addr <= 1'b0;
    i_sw_data <= 16'hbeef;
    lat <= 4'h0;
    cmd(7);
    i_sw_data <= 16'h0000;
    cmd(6);
    chk("display", 32'h0000_beef, o_display);
    chk("bus cycles", 3, n_req);
    i_key_enable <= 1'b0;
    cmd(6);
    press(2);
    chk("bus cycles", 3, n_req);
    chk("halts", 0, n_halt);
    i_key_enable <= 1'b1;
    press(2);
    chk("halts", 1, n_halt);
    i_cpu_running <= 1'b0;
    press(2);
    chk("halts", 1, n_halt);
    press(3);
    chk("runs", 1, n_run);
    press(4);
    chk("loads", 0, n_load);
    press(5);
    chk("master reset", 1, o_master_reset);
    chk("armed", 1, o_led_load);
    cmd(6);
    chk("bus cycles", 3, n_req);
    for (int i = 0; i < 40 && o_master_reset; i++)
      ticks(1);
    press(4);
    chk("loads", 1, n_load);
    chk("armed", 0, o_led_load);
    press(4);
    chk("loads", 1, n_load);
    press(0);
    chk("attention", 1, o_irq_operator_attention);
    i_irq_operator_attention_ack <= 1'b1;
    ticks(2);
    i_irq_operator_attention_ack <= 1'b0;
    chk("attention", 0, o_irq_operator_attention);
    press(1);
    chk("irq inhibit", 1, o_irq_inhibit);
    press(0);
    chk("attention", 0, o_irq_operator_attention);
    i_irq_operator_attention_ack <= 1'b1;
    ticks(2);
    i_irq_operator_attention_ack <= 1'b0;
    press(1);
    chk("inhibit", 0, o_led_inhibit);
    i_sw_data <= 16'h0f0f;
    press(8);
    chk("display", 32'h0000_0f0f, o_display);
    i_power_event_interrupt_switch <= 1'b0;
    ticks(6);
    chk("power block", 1, o_power_irq_block);
    i_power_event_interrupt_switch <= 1'b1;
    ticks(6);
    chk("power block", 0, o_power_irq_block);
    results();
  end
endmodule : ocp_panel_tb

// >>> ocp_pkg.sv
package ocp_pkg;

  // data path widths
  localparam int WORD_W = 16;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = 4;

  // clock and master reset timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RESET_HOLD_NS = 1000;

  // register byte offsets
  localparam logic [AXI_AW-1:0] REG_DISPLAY = 8'h00;
  localparam logic [AXI_AW-1:0] REG_CONTROL = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;

  // control register fields
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_PWR_BLOCK_BIT = 1;

  // status register fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_HALT_BIT = 1;
  localparam int STAT_IDLE_BIT = 2;
  localparam int STAT_DONE_BIT = 3;
  localparam int STAT_ARMED_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_MRESET_BIT = 6;
  localparam int STAT_OPERATOR_ATTENTION_BIT = 7;

  // reset values
  localparam logic [WORD_W-1:0] DISPLAY_RST = 16'h0000;
  localparam logic INHIBIT_RST = 1'b0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // positions in the synchronised switch vector
  localparam int SW_OPERATOR_ATTENTION = 0;
  localparam int SW_INHIBIT = 1;
  localparam int SW_HALT = 2;
  localparam int SW_RUN = 3;
  localparam int SW_LOAD = 4;
  localparam int SW_RESET = 5;
  localparam int SW_READ = 6;
  localparam int SW_WRITE = 7;
  localparam int SW_LOADREG = 8;
  localparam int SW_N = 9;
  localparam int LV_SEL = 9;
  localparam int LV_KEY = 10;
  localparam int LV_PWR = 11;
  localparam int DATA_LSB = 12;

  // bus master cycle states
  typedef enum logic [0:0] {
    OCP_BM_IDLE = 1'b0,
    OCP_BM_CYCLE = 1'b1
  } ocp_bm_state_t;

endpackage : ocp_pkg
